// File: dv/test_acc_regs.sv
// Testbench for the calibration register bank: reset values, modes, tuning, interrupts
// Assumes acc_regs answers reads one cycle after the strobe and never stalls
`timescale 1ns/1ps
module test_acc_regs;
  logic               clk        = 1'b0;
  logic               rst_n      = 1'b0;
  acc_pkg::acc_req_t  req        = '0;
  logic [7:0]         rdata;
  acc_pkg::acc_mode_t mode;
  logic               cal_reset;
  logic               trim_clear;
  logic               fg_running;
  logic               link_enable;
  logic               div_digital_en;
  logic               div_serial_en;
  logic               irq;
  logic [7:0]         exp_q[$];
  logic [7:0]         msk_q[$];
  logic [7:0]         last_rd    = 8'h00;
  logic [7:0]         me;
  logic [7:0]         mm;
  logic               rd_q       = 1'b0;
  int                 failures   = 0;
  int                 n_compared = 0;
  integer             seed       = 32'ha13c;
  logic [7:0]         r;
  logic [7:0]         a;
  logic [7:0]         b;
  int                 tc;
  int                 dv;
  int                 ds;
  int                 fr;

  always #4 clk = ~clk;

  acc_regs #(.FG_LEN(4), .DIV(2)) acc_regs_i (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .mode(mode),
    .cal_reset(cal_reset), .trim_clear(trim_clear), .fg_running(fg_running),
    .link_enable(link_enable), .div_digital_en(div_digital_en),
    .div_serial_en(div_serial_en), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compare and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask : chk1

  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // Register port master
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
    @(posedge clk);
  endtask : rd

  task automatic idle(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic poll(input logic [7:0] ad, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      rd(ad, 8'h00, 8'h00);
      idle(2);
      if (last_rd[0] === 1'b1) break;
    end
    n_compared++;
    if (i == lim) begin
      failures++;
      $display("mismatch at %0t: status never set at %h", $time, ad);
      report_and_stop();
    end
  endtask : poll

  ////////////////////////////////////////////////////////////////////////////
  // Read data watcher: oldest note against the answer
  always @(posedge clk) begin
    if (rd_q && exp_q.size() > 0) begin
      last_rd = rdata;
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      if (mm !== 8'h00) chk(rdata & mm, me & mm, "read data");
    end
    rd_q <= req.rd;
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: run did not finish", $time);
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    #1;
    chk1(cal_reset, 1'b0, "run after reset");
    chk({2'b00, mode}, 8'h30, "mode after reset");
    rd(8'h61, acc_pkg::RST_CAL_EN, 8'hff);
    rd(8'h62, acc_pkg::RST_CFG_A, 8'hff);
    rd(8'h65, acc_pkg::RST_CFG_B, 8'hff);
    rd(8'h5e, 8'h01, 8'hff);
    rd(8'h5d, acc_pkg::RST_VCO_CTRL, 8'hff);
    rd(8'h33, 8'h00, 8'hff);
    idle(1);
    poll(8'h6a, 20);
    // Run cleared: dividers frozen, link refused
    wr(8'h61, 8'h00);
    wr(8'h72, 8'h01);
    idle(2);
    #1;
    chk1(cal_reset, 1'b1, "held in reset");
    dv = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      dv += int'(div_digital_en | div_serial_en);
    end
    chk(8'(dv), 8'h00, "divider pulses while stopped");
    chk1(link_enable, 1'b0, "link while stopped");
    // Random modes, each loaded with run cleared then rerun
    for (int k = 0; k < 8; k++) begin
      r = 8'($random(seed));
      a = r & acc_pkg::MSK_CFG_A;
      b = {5'h00, r[4] & r[1], 2'b01};
      wr(8'h61, 8'h00);
      wr(8'h62, a);
      wr(8'h65, b);
      wr(8'h61, 8'h01);
      req <= '0;
      tc = 0;
      dv = 0;
      ds = 0;
      fr = 0;
      repeat (12) begin
        @(posedge clk);
        #1;
        tc += int'(trim_clear);
        dv += int'(div_digital_en);
        ds += int'(div_serial_en);
        fr += int'(fg_running);
      end
      chk(8'(tc), 8'h01, "calibration value reset");
      chk1(dv > 1, 1'b1, "dividers running");
      chk(8'(ds), 8'h06, "serial divider pulses");
      chk(8'(fr), a[0] ? 8'h04 : 8'h00, "foreground busy cycles");
      chk({2'b00, mode}, {2'b00, 1'b1, a[0], a[1], a[2] & a[0], a[3] & a[1], b[2]},
          "mode");
      rd(8'h62, a, 8'hff);
      rd(8'h65, b, 8'hff);
      rd(8'h6a, 8'h01, 8'h01);
      idle(1);
    end
    // Link on only while running
    wr(8'h72, 8'h01);
    idle(2);
    #1;
    chk1(link_enable, 1'b1, "link on");
    wr(8'h72, 8'h00);
    // Tuning with interrupt masked, then unmasked
    wr(8'h71, 8'h00);
    rd(8'h70, 8'h00, 8'h00);
    wr(8'h5c, 8'h01);
    wr(8'h5d, 8'h01);
    rd(8'h5e, 8'h00, 8'hff);
    wr(8'h5c, 8'h00);
    idle(3);
    rd(8'h5e, 8'h00, 8'hff);
    idle(1);
    poll(8'h5e, 400);
    rd(8'h5e, 8'h01, 8'hff);
    rd(8'h59, 8'h00, 8'h80);
    wr(8'h59, 8'h25);
    rd(8'h59, 8'h25, 8'hff);
    idle(2);
    #1;
    chk1(irq, 1'b0, "masked interrupt");
    wr(8'h71, 8'h01);
    idle(2);
    #1;
    chk1(irq, 1'b1, "unmasked interrupt");
    rd(8'h70, 8'h01, 8'h01);
    idle(3);
    #1;
    chk1(irq, 1'b0, "interrupt after clear");
    rd(8'h70, 8'h00, 8'h01);
    idle(2);
    // Second reset in mid-run
    rst_n <= 1'b0;
    idle(3);
    rst_n <= 1'b1;
    idle(1);
    rd(8'h61, acc_pkg::RST_CAL_EN, 8'hff);
    rd(8'h5d, acc_pkg::RST_VCO_CTRL, 8'hff);
    idle(4);
    report_and_stop();
  end
endmodule : test_acc_regs

// File: hw/acc_pkg.sv
// Package: register map, field positions, reset values and timing for the calibration bank
// Assumes a single 125 MHz clock and an 8-bit register port
package acc_pkg;
  localparam logic [7:0] OFF_CAL_EN    = 8'h61;
  localparam logic [7:0] OFF_CFG_A     = 8'h62;
  localparam logic [7:0] OFF_CFG_B     = 8'h65;
  localparam logic [7:0] OFF_VCO_STAT  = 8'h5e;
  localparam logic [7:0] OFF_PLL_RST   = 8'h5c;
  localparam logic [7:0] OFF_VCO_CTRL  = 8'h5d;
  localparam logic [7:0] OFF_VCO_TRIM  = 8'h59;
  localparam logic [7:0] OFF_FG_STAT   = 8'h6a;
  localparam logic [7:0] OFF_INT_STAT  = 8'h70;
  localparam logic [7:0] OFF_INT_MASK  = 8'h71;
  localparam logic [7:0] OFF_LINK_EN   = 8'h72;

  localparam int BIT_RUN      = 0;
  localparam int BIT_FG_SEL   = 0;
  localparam int BIT_BG_EN    = 1;
  localparam int BIT_FG_OS    = 2;
  localparam int BIT_BG_OS    = 3;
  localparam int BIT_OS_REF   = 2;
  localparam int BIT_VCO_EN   = 0;
  localparam int BIT_PLL_RST  = 0;

  localparam logic [7:0] RST_CAL_EN   = 8'h01;
  localparam logic [7:0] RST_CFG_A    = 8'h01;
  localparam logic [7:0] RST_CFG_B    = 8'h01;
  localparam logic [7:0] RST_VCO_CTRL = 8'h40;
  localparam logic [7:0] RST_PLL_RST  = 8'h00;
  localparam logic [7:0] RST_VCO_TRIM = 8'h00;
  localparam logic [7:0] MSK_CFG_A    = 8'h0f;
  localparam logic [7:0] MSK_CFG_B    = 8'h07;
  localparam logic [7:0] MSK_VCO_CTRL = 8'h7f;

  localparam int TUNE_STEPS   = 16;
  localparam int FG_CYCLES    = 64;
  localparam int DIV_RATIO    = 4;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acc_req_t;

  typedef struct packed {
    logic run;
    logic fg_sel;
    logic bg_en;
    logic fg_os;
    logic bg_os;
    logic os_ref;
  } acc_mode_t;
endpackage : acc_pkg

// File: hw/acc_regs.sv
// Calibration control and status register bank with interrupt and divider reset
// Assumes a one-cycle strobe master; read data stand one cycle after the read strobe
`timescale 1ns/1ps
// Notes on behaviour
// - Tune-done reads bit0; other bits zero
// - Run enable resets to one; clear holds reset
// - Clearing run enable resets clock dividers
// - Bit3 enables background offset trim
// - Bit2 enables foreground offset trim
// - Bit1 enables continuous background trim
// - Bit0 resets values, optionally runs foreground
// - Offset reference zero targets mid-code
// - Offset reference one matches spare converter
// - Tuning starts when PLL reset goes low
// - Foreground done high after run or skip
module acc_regs #(
  parameter int FG_LEN = acc_pkg::FG_CYCLES,
  parameter int DIV    = acc_pkg::DIV_RATIO
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register port
  input  wire acc_pkg::acc_req_t   req,
  output logic [7:0]               rdata,
  // Calibration outputs
  output acc_pkg::acc_mode_t       mode,
  output logic                     cal_reset,
  output logic                     trim_clear,
  output logic                     fg_running,
  output logic                     link_enable,
  output logic                     div_digital_en,
  output logic                     div_serial_en,
  output logic                     irq
);
  logic [7:0] cal_en;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [7:0] vco_ctrl;
  logic [7:0] pll_rst;
  logic [7:0] vco_trim;
  logic [1:0] int_stat;
  logic [1:0] int_mask;
  logic       foreground_trim_done;
  logic       fg_busy;
  logic [7:0] fg_cnt;
  logic [7:0] div_cnt;
  logic       run_q;
  logic       tune_busy;
  logic       tune_done;
  logic       tune_load;
  logic [6:0] tune_trim;
  logic       tune_done_q;
  logic       foreground_trim_done_q;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Tuning engine
  acc_vco_tuner #(.STEPS(acc_pkg::TUNE_STEPS)) u_tuner (
    .clk       (clk),
    .rst_n     (rst_n),
    .enable    (vco_ctrl[acc_pkg::BIT_VCO_EN]),
    .pll_reset (pll_rst[acc_pkg::BIT_PLL_RST]),
    .settle    (vco_ctrl[6:4]),
    .busy      (tune_busy),
    .done      (tune_done),
    .load      (tune_load),
    .trim      (tune_trim)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_en   <= acc_pkg::RST_CAL_EN;
      cfg_a    <= acc_pkg::RST_CFG_A;
      cfg_b    <= acc_pkg::RST_CFG_B;
      vco_ctrl <= acc_pkg::RST_VCO_CTRL;
      pll_rst  <= acc_pkg::RST_PLL_RST;
      int_mask <= 2'b00;
    end else if (req.wr) begin
      if (hit(req.addr, acc_pkg::OFF_CAL_EN)) begin
        cal_en <= {7'h00, req.wdata[acc_pkg::BIT_RUN]};
      end else if (hit(req.addr, acc_pkg::OFF_CFG_A)) begin
        cfg_a <= req.wdata & acc_pkg::MSK_CFG_A;
      end else if (hit(req.addr, acc_pkg::OFF_CFG_B)) begin
        cfg_b <= req.wdata & acc_pkg::MSK_CFG_B;
      end else if (hit(req.addr, acc_pkg::OFF_VCO_CTRL)) begin
        vco_ctrl <= req.wdata & acc_pkg::MSK_VCO_CTRL;
      end else if (hit(req.addr, acc_pkg::OFF_PLL_RST)) begin
        pll_rst <= {7'h00, req.wdata[acc_pkg::BIT_PLL_RST]};
      end else if (hit(req.addr, acc_pkg::OFF_INT_MASK)) begin
        int_mask <= req.wdata[1:0];
      end
    end
  end

  // Trim: loaded by tuning, else writable when tuning idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vco_trim <= acc_pkg::RST_VCO_TRIM;
    end else if (tune_load) begin
      vco_trim <= {1'b0, tune_trim};
    end else if (req.wr && hit(req.addr, acc_pkg::OFF_VCO_TRIM) && !tune_busy) begin
      vco_trim <= {1'b0, req.wdata[6:0]};
    end
  end

  // Link enable only accepted while calibration runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_enable <= 1'b0;
    end else if (!cal_en[acc_pkg::BIT_RUN]) begin
      link_enable <= 1'b0;
    end else if (req.wr && hit(req.addr, acc_pkg::OFF_LINK_EN)) begin
      link_enable <= req.wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= '0;
      cal_reset <= 1'b1;
    end else begin
      mode.run    <= cal_en[acc_pkg::BIT_RUN];
      cal_reset   <= !cal_en[acc_pkg::BIT_RUN];
      mode.fg_sel <= cfg_a[acc_pkg::BIT_FG_SEL];
      mode.bg_en  <= cfg_a[acc_pkg::BIT_BG_EN];
      mode.fg_os  <= cfg_a[acc_pkg::BIT_FG_OS] & cfg_a[acc_pkg::BIT_FG_SEL];
      mode.bg_os  <= cfg_a[acc_pkg::BIT_BG_OS] & cfg_a[acc_pkg::BIT_BG_EN];
      mode.os_ref <= cfg_b[acc_pkg::BIT_OS_REF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Foreground sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q      <= 1'b0;
      fg_busy    <= 1'b0;
      foreground_trim_done    <= 1'b0;
      fg_cnt     <= 8'h00;
      trim_clear <= 1'b0;
      fg_running <= 1'b0;
    end else begin
      run_q      <= cal_en[acc_pkg::BIT_RUN];
      trim_clear <= 1'b0;
      if (!cal_en[acc_pkg::BIT_RUN]) begin
        fg_busy <= 1'b0;
        foreground_trim_done <= 1'b0;
      end else if (!run_q) begin
        trim_clear <= 1'b1;
        if (cfg_a[acc_pkg::BIT_FG_SEL]) begin
          fg_busy <= 1'b1;
          fg_cnt  <= 8'(FG_LEN - 1);
        end else begin
          foreground_trim_done <= 1'b1;
        end
      end else if (fg_busy) begin
        if (fg_cnt == 8'h00) begin
          fg_busy <= 1'b0;
          foreground_trim_done <= 1'b1;
        end else begin
          fg_cnt <= fg_cnt - 8'h01;
        end
      end
      fg_running <= fg_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider enables, held in reset while calibration stops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt        <= 8'h00;
      div_digital_en <= 1'b0;
      div_serial_en  <= 1'b0;
    end else if (!cal_en[acc_pkg::BIT_RUN]) begin
      div_cnt        <= 8'h00;
      div_digital_en <= 1'b0;
      div_serial_en  <= 1'b0;
    end else begin
      div_cnt        <= (div_cnt == 8'(DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
      div_digital_en <= (div_cnt == 8'(DIV - 1));
      div_serial_en  <= (div_cnt == 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: bit0 tune done, bit1 foreground done; read clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tune_done_q <= 1'b1;
      foreground_trim_done_q   <= 1'b0;
      int_stat    <= 2'b00;
    end else begin
      tune_done_q <= tune_done;
      foreground_trim_done_q   <= foreground_trim_done;
      int_stat    <= ((req.rd && hit(req.addr, acc_pkg::OFF_INT_STAT)) ? 2'b00 : int_stat)
                   | {foreground_trim_done & !foreground_trim_done_q, tune_done & !tune_done_q};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  always_comb begin
    next_rdata = 8'h00;
    if (hit(req.addr, acc_pkg::OFF_CAL_EN)) begin
      next_rdata = cal_en;
    end else if (hit(req.addr, acc_pkg::OFF_CFG_A)) begin
      next_rdata = cfg_a;
    end else if (hit(req.addr, acc_pkg::OFF_CFG_B)) begin
      next_rdata = cfg_b;
    end else if (hit(req.addr, acc_pkg::OFF_VCO_STAT)) begin
      next_rdata = {7'h00, tune_done};
    end else if (hit(req.addr, acc_pkg::OFF_VCO_CTRL)) begin
      next_rdata = vco_ctrl;
    end else if (hit(req.addr, acc_pkg::OFF_PLL_RST)) begin
      next_rdata = pll_rst;
    end else if (hit(req.addr, acc_pkg::OFF_VCO_TRIM)) begin
      next_rdata = vco_trim;
    end else if (hit(req.addr, acc_pkg::OFF_FG_STAT)) begin
      next_rdata = {7'h00, foreground_trim_done};
    end else if (hit(req.addr, acc_pkg::OFF_INT_STAT)) begin
      next_rdata = {6'h00, int_stat};
    end else if (hit(req.addr, acc_pkg::OFF_INT_MASK)) begin
      next_rdata = {6'h00, int_mask};
    end else if (hit(req.addr, acc_pkg::OFF_LINK_EN)) begin
      next_rdata = {7'h00, link_enable};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= req.rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_run_reset;
    @(posedge clk) disable iff (!rst_n)
      $fell(cal_en[0]) |=> cal_reset && !div_digital_en;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("run clear no reset");

  property p_div_hold;
    @(posedge clk) disable iff (!rst_n)
      !cal_en[0] |=> !div_digital_en && !div_serial_en;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider not held");

  property p_bg_os;
    @(posedge clk) disable iff (!rst_n)
      mode.bg_os |-> $past(cfg_a[1]);
  endproperty
  a_bg_os: assert property (p_bg_os) else $error("bg offset without bg");

  property p_fg_os;
    @(posedge clk) disable iff (!rst_n)
      ##1 (mode.fg_os == $past(cfg_a[2] & cfg_a[0]));
  endproperty
  a_fg_os: assert property (p_fg_os) else $error("fg offset mismatch");

  property p_bg;
    @(posedge clk) disable iff (!rst_n)
      ##1 (mode.bg_en == $past(cfg_a[1]));
  endproperty
  a_bg: assert property (p_bg) else $error("bg enable mismatch");

  property p_skip;
    @(posedge clk) disable iff (!rst_n)
      $rose(cal_en[0]) && !cfg_a[0] |=> foreground_trim_done && trim_clear;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not done");

  property p_offset_reference_select;
    @(posedge clk) disable iff (!rst_n)
      ##1 (mode.os_ref == $past(cfg_b[2]));
  endproperty
  a_offset_reference_select: assert property (p_offset_reference_select) else $error("offset ref mismatch");

  property p_tune_low;
    @(posedge clk) disable iff (!rst_n)
      req.rd && hit(req.addr, acc_pkg::OFF_VCO_STAT) && tune_busy |=> rdata == 8'h00;
  endproperty
  a_tune_low: assert property (p_tune_low) else $error("done during tuning");

  property p_stat_read;
    @(posedge clk) disable iff (!rst_n)
      req.rd && hit(req.addr, acc_pkg::OFF_VCO_STAT) |=> rdata == {7'h00, $past(tune_done)};
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_tune_start;
    @(posedge clk) disable iff (!rst_n)
      $fell(pll_rst[0]) && vco_ctrl[0] && !tune_busy |=> ##1 tune_busy;
  endproperty
  a_tune_start: assert property (p_tune_start) else $error("tuning not started");

  c_fg_run: cover property (@(posedge clk) disable iff (!rst_n) $rose(foreground_trim_done) && cfg_a[0]);
  c_tune:   cover property (@(posedge clk) disable iff (!rst_n) $rose(tune_load));
  c_irq:    cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_link:   cover property (@(posedge clk) disable iff (!rst_n) $rose(link_enable));
endmodule : acc_regs

// File: hw/acc_vco_tuner.sv
// VCO tuning engine: steps the trim after the PLL reset is released
// Assumes controls are stable while tuning runs
`timescale 1ns/1ps
module acc_vco_tuner #(
  parameter int STEPS = acc_pkg::TUNE_STEPS
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       enable,
  input  wire logic       pll_reset,
  input  wire logic [2:0] settle,
  // Status
  output logic            busy,
  output logic            done,
  output logic            load,
  output logic [6:0]      trim
);
  typedef enum logic [1:0] {ACC_IDLE, ACC_SETTLE, ACC_FIN} acc_tst_t;
  acc_tst_t   state;
  logic [7:0] step;
  logic [4:0] wait_cnt;
  logic       pll_reset_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_reset_q <= 1'b0;
    end else begin
      pll_reset_q <= pll_reset;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ACC_IDLE;
      step     <= 8'h00;
      wait_cnt <= 5'h00;
      trim     <= 7'h00;
      load     <= 1'b0;
    end else begin
      load <= 1'b0;
      case (state)
        ACC_IDLE: begin
          if (pll_reset_q && !pll_reset && enable) begin
            state    <= ACC_SETTLE;
            step     <= 8'h00;
            wait_cnt <= {settle, 2'b00};
            trim     <= 7'h40;
          end
        end
        ACC_SETTLE: begin
          if (pll_reset) begin
            state <= ACC_IDLE;
          end else if (wait_cnt != 5'h00) begin
            wait_cnt <= wait_cnt - 5'h01;
          end else if (step == 8'(STEPS - 1)) begin
            state <= ACC_FIN;
            load  <= 1'b1;
          end else begin
            step     <= step + 8'h01;
            trim     <= trim ^ 7'(step);
            wait_cnt <= {settle, 2'b00};
          end
        end
        default: begin
          if (pll_reset) begin
            state <= ACC_IDLE;
          end
        end
      endcase
    end
  end

  assign busy = (state == ACC_SETTLE);
  // Done when finished or when idle with tuning disabled
  assign done = (state == ACC_FIN) || (state == ACC_IDLE && !enable);
endmodule : acc_vco_tuner
